// ===== core/ebtp_timer.sv
// Function
// - the 4-bit clock field picks stop, system clock, fast osc, crystal, slow osc, comparator, op-amp or a pin edge.
// - the mode bit selects periodic square wave at 0 and pulse-width modulation at 1.
// - control bit 0 set to 1 inverts the output waveform, 0 leaves it as is.
// - divider bit 7 selects 8-bit resolution at 0 and the build-time reduced resolution at 1.
// - the prescale field divides the selected clock by 1, 4, 16 or 64.
// - the 5-bit scaler value S divides the prescaled clock further by S plus one.
// - periodic mode gives 50% duty at clock over twice (bound+1) times prescale times (scaler+1).
// - 8-bit pwm has a period of 256 counter clocks and a high time of bound+1 of them.
// - 6-bit pwm has a period of 64 counter clocks and a high time of bound+1 of them.
// - the bound is the period limit in periodic mode and the duty compare in pwm mode.
// - software reads and writes the counter, a write preloads it, and it resets to zero.
// - with the fast oscillator selected the emulator halt does not stop counting.
// - in periodic mode the counter returns to zero when it reaches the bound.
// - with comparator gating built in, a comparator result of 1 suppresses the pwm output.
//
// Decided for this implementation: register access over APB.
`include "ebtp_regs.svh"

module ebtp_timer #(
	parameter int PADDR_W  = 8,
	parameter int RED_BITS = 6,
	parameter bit GATE_CMP = 1'b0,
	parameter bit GATE_OPA = 1'b0
) (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// clock sources, asynchronous
	input  wire logic               fast_internal_oscillator,
	input  wire logic               crystal_oscillator,
	input  wire logic               slow_internal_oscillator,
	input  wire logic               comparator_result,
	input  wire logic               op_amp_result,
	input  wire logic               port_a_line_zero,
	input  wire logic               port_b_line_zero,
	input  wire logic               port_a_line_four,
	// debug
	input  wire logic               in_circuit_emulator_halt,
	// waveform pins
	output logic                    port_b_line_five,
	output logic                    port_b_line_five_oe,
	output logic                    port_b_line_six,
	output logic                    port_b_line_six_oe,
	output logic                    port_b_line_seven,
	output logic                    port_b_line_seven_oe
);
	import ebtp_pkg::*;

	// reduced top is fixed at build time; software only picks it or the full 8 bits
	localparam logic [7:0] RED_TOP = 8'((1 << RED_BITS) - 1);

	logic [7:0]             ctrl_q;
	logic [7:0]             div_q;
	logic [7:0]             lim_q;
	logic [7:0]             cnt_q;
	logic [7:0]             cnt_d;
	logic [7:0]             rd_d;
	logic [7:0]             top;
	logic [31:0]            prdata_q;
	logic                   wave_q;
	logic                   wave_d;
	logic                   out_q;
	logic                   gate;
	logic                   sel_tick;
	logic                   tick;
	logic                   setup;
	logic                   access;
	logic                   aligned;
	logic                   hit_ctrl;
	logic                   hit_cnt;
	logic                   hit_div;
	logic                   hit_lim;
	logic                   hit_any;
	logic                   cnt_wr;
	logic [PADDR_W-3:0]     widx;
	logic [`EBTP_SRC_N-1:0] raw;
	logic [`EBTP_SRC_N-1:0] s1_q;
	logic [`EBTP_SRC_N-1:0] s2_q;
	logic [`EBTP_SRC_N-1:0] s3_q;
	logic [`EBTP_SRC_N-1:0] stab_q;
	logic [`EBTP_SRC_N-1:0] stab_d;
	logic [`EBTP_SRC_N-1:0] rise;
	logic [`EBTP_SRC_N-1:0] fall;
	ebtp_csel_t             csel;
	ebtp_mode_t             mode;
	ebtp_osel_t             osel;

	// the divider only advances on selected source ticks, so it pauses with the source
	ebtp_tick_if tk ();

	ebtp_divider u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (tk.div)
	);

	// apb decode, zero wait states
	assign setup    = psel && !penable;
	assign access   = psel && penable;
	assign aligned  = (paddr[1:0] == 2'h0);
	assign widx     = paddr[PADDR_W-1:2];
	assign hit_ctrl = aligned && (widx == (PADDR_W-2)'(`EBTP_IDX_CTRL));
	assign hit_cnt  = aligned && (widx == (PADDR_W-2)'(`EBTP_IDX_CNT));
	assign hit_div  = aligned && (widx == (PADDR_W-2)'(`EBTP_IDX_DIV));
	assign hit_lim  = aligned && (widx == (PADDR_W-2)'(`EBTP_IDX_LIM));
	assign hit_any  = hit_ctrl || hit_cnt || hit_div || hit_lim;
	assign cnt_wr   = access && pwrite && hit_cnt;
	assign pready   = 1'b1;
	assign pslverr  = access && !hit_any;
	assign prdata   = prdata_q;

	// write-only registers read back as zero
	always_comb begin
		rd_d = 8'h00;
		if (hit_ctrl) begin
			rd_d = ctrl_q;
		end else if (hit_cnt) begin
			rd_d = cnt_q;
		end
	end

	// captured in setup so the word stands unchanged through the whole access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_q <= {24'h000000, rd_d};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `EBTP_CTRL_RST;
		end else if (access && pwrite && hit_ctrl) begin
			ctrl_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= `EBTP_DIV_RST;
		end else if (access && pwrite && hit_div) begin
			div_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_q <= `EBTP_LIM_RST;
		end else if (access && pwrite && hit_lim) begin
			lim_q <= pwdata[7:0];
		end
	end

	assign csel = ebtp_csel_t'(ctrl_q[`EBTP_CSEL_HI:`EBTP_CSEL_LO]);
	assign mode = ebtp_mode_t'(ctrl_q[`EBTP_MODE_BIT]);
	assign osel = ebtp_osel_t'(ctrl_q[`EBTP_OSEL_HI:`EBTP_OSEL_LO]);

	// source sampling: a level counts only once stages two and three agree
	assign raw = {port_a_line_four, port_b_line_zero, port_a_line_zero, op_amp_result,
		comparator_result, slow_internal_oscillator, crystal_oscillator, fast_internal_oscillator};
	assign stab_d = (s2_q & s3_q) | (stab_q & (s2_q | s3_q));
	assign rise   = stab_d & ~stab_q;
	assign fall   = ~stab_d & stab_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			stab_q <= '0;
		end else begin
			s1_q   <= raw;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			stab_q <= stab_d;
		end
	end

	always_comb begin
		sel_tick = 1'b0;
		case (csel)
			CS_SYS:  sel_tick = 1'b1;
			CS_FAST: sel_tick = rise[`EBTP_SRC_FAST];
			CS_XTAL: sel_tick = rise[`EBTP_SRC_XTAL];
			CS_SLOW: sel_tick = rise[`EBTP_SRC_SLOW];
			CS_CMP:  sel_tick = rise[`EBTP_SRC_CMP];
			CS_OPA:  sel_tick = rise[`EBTP_SRC_OPA];
			CS_A0_R: sel_tick = rise[`EBTP_SRC_A0];
			CS_A0_F: sel_tick = fall[`EBTP_SRC_A0];
			CS_B0_R: sel_tick = rise[`EBTP_SRC_B0];
			CS_B0_F: sel_tick = fall[`EBTP_SRC_B0];
			CS_A4_R: sel_tick = rise[`EBTP_SRC_A4];
			CS_A4_F: sel_tick = fall[`EBTP_SRC_A4];
			default: sel_tick = 1'b0;
		endcase
	end

	// halt gates every source but the fast oscillator
	assign tk.src_tick = sel_tick && (!in_circuit_emulator_halt || csel == CS_FAST);
	assign tk.pre      = ebtp_pre_t'(div_q[`EBTP_PRE_HI:`EBTP_PRE_LO]);
	assign tk.scale    = div_q[`EBTP_SCL_HI:`EBTP_SCL_LO];
	// rewriting the divider restarts both stages so the new rate starts clean
	assign tk.restart  = access && pwrite && hit_div;
	assign tick        = tk.cnt_tick;

	assign top = div_q[`EBTP_RES_BIT] ? RED_TOP : 8'hFF;

	// a preload above top in pwm mode wraps at the next tick instead of running on
	always_comb begin
		cnt_d  = cnt_q;
		wave_d = wave_q;
		if (tick) begin
			if (mode == MD_PERIOD) begin
				// wrap at bound and toggle for 50% duty
				if (cnt_q == lim_q) begin
					cnt_d  = 8'h00;
					wave_d = !wave_q;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end else begin
				cnt_d  = (cnt_q >= top) ? 8'h00 : cnt_q + 8'h01;
				wave_d = (cnt_d <= lim_q);
			end
		end
	end

	// counter preload wins over a tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= `EBTP_CNT_RST;
		end else if (cnt_wr) begin
			cnt_q <= pwdata[7:0];
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_q <= 1'b0;
		end else begin
			wave_q <= wave_d;
		end
	end

	assign gate = (mode == MD_PWM) && ((GATE_CMP && stab_q[`EBTP_SRC_CMP]) || (GATE_OPA && stab_q[`EBTP_SRC_OPA]));

	// polarity, a gated output sits low regardless of polarity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 1'b0;
		end else begin
			out_q <= gate ? 1'b0 : (wave_q ^ ctrl_q[`EBTP_INV_BIT]);
		end
	end

	// every pin carries the wave; only the enables decide which one drives
	assign port_b_line_five     = out_q;
	assign port_b_line_six      = out_q;
	assign port_b_line_seven    = out_q;
	assign port_b_line_five_oe  = (osel == OS_B5);
	assign port_b_line_six_oe   = (osel == OS_B6);
	assign port_b_line_seven_oe = (osel == OS_B7);

	default clocking dcb @(posedge pclk); endclocking
	default disable iff (!presetn);

	stop_no_tick_a: assert property (csel == CS_STOP |-> !tk.src_tick)
		else $error("source tick while stopped");
	sysclk_tick_a: assert property (csel == CS_SYS && !in_circuit_emulator_halt |-> tk.src_tick)
		else $error("system clock source gave no tick");
	halt_gate_a: assert property (in_circuit_emulator_halt && csel != CS_FAST |-> !tk.src_tick)
		else $error("tick passed during emulator halt");
	fast_free_a: assert property (in_circuit_emulator_halt && csel == CS_FAST && rise[`EBTP_SRC_FAST]
		|-> tk.src_tick)
		else $error("fast oscillator stopped by halt");
	period_wrap_a: assert property (tick && !cnt_wr && mode == MD_PERIOD && cnt_q == lim_q
		|=> cnt_q == 8'h00 && wave_q != $past(wave_q))
		else $error("periodic wrap or toggle missing");
	pwm_wrap_a: assert property (tick && !cnt_wr && mode == MD_PWM && cnt_q == top
		|=> cnt_q == 8'h00 && wave_q)
		else $error("pwm wrap did not raise output");
	pwm_full_a: assert property (tick && !cnt_wr && mode == MD_PWM && !div_q[`EBTP_RES_BIT]
		&& cnt_q == RED_TOP |=> cnt_q == RED_TOP + 8'h01)
		else $error("8-bit pwm wrapped early");
	pwm_duty_a: assert property (tick && !cnt_wr && mode == MD_PWM && cnt_q == lim_q && cnt_q < top
		|=> !wave_q)
		else $error("output stayed high past bound");
	preload_a: assert property (cnt_wr |=> cnt_q == $past(pwdata[7:0]))
		else $error("counter preload lost");
	invert_a: assert property (!gate |=> out_q == ($past(wave_q) ^ $past(ctrl_q[`EBTP_INV_BIT])))
		else $error("output polarity wrong");
	gate_low_a: assert property (gate |=> !out_q)
		else $error("gated pwm output not suppressed");
	hold_count_a: assert property (!tick && !cnt_wr |=> $stable(cnt_q) && $stable(wave_q))
		else $error("counter moved without a tick");

	// register writes land at the access edge, counter reads are captured in setup
	ctrl_write_a: assert property (access && pwrite && hit_ctrl |=> ctrl_q == $past(pwdata[7:0]))
		else $error("control write lost");
	div_write_a: assert property (access && pwrite && hit_div |=> div_q == $past(pwdata[7:0]))
		else $error("divider write lost");
	lim_write_a: assert property (access && pwrite && hit_lim |=> lim_q == $past(pwdata[7:0]))
		else $error("limit write lost");
	count_read_a: assert property (setup && !pwrite && hit_cnt |=> prdata == {24'h000000, $past(cnt_q)})
		else $error("counter readback wrong");

	// counting and waveform steps
	period_step_a: assert property (tick && !cnt_wr && mode == MD_PERIOD && cnt_q != lim_q
		|=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("periodic count did not step");
	period_hold_a: assert property (tick && mode == MD_PERIOD && cnt_q != lim_q |=> $stable(wave_q))
		else $error("square wave toggled before bound");
	reduced_wrap_a: assert property (tick && !cnt_wr && mode == MD_PWM && div_q[`EBTP_RES_BIT]
		&& cnt_q == RED_TOP |=> cnt_q == 8'h00)
		else $error("reduced pwm did not wrap at top");

	period_toggle_c: cover property (tick && mode == MD_PERIOD && cnt_q == lim_q);
	pwm_wrap_c: cover property (tick && mode == MD_PWM && cnt_q == top);
	preload_c: cover property (cnt_wr);
	gate_c: cover property (gate && wave_q);
	reduced_wrap_c: cover property (tick && mode == MD_PWM && div_q[`EBTP_RES_BIT] && cnt_q == RED_TOP);
endmodule : ebtp_timer

// ===== core/ebtp_regs.svh
`ifndef EBTP_REGS_SVH
`define EBTP_REGS_SVH

// register indices, byte address is index * 4
`define EBTP_IDX_CTRL 6'h32
`define EBTP_IDX_CNT  6'h33
`define EBTP_IDX_DIV  6'h34
`define EBTP_IDX_LIM  6'h38

// reset values
`define EBTP_CTRL_RST 8'h00
`define EBTP_CNT_RST  8'h00
`define EBTP_DIV_RST  8'h00
`define EBTP_LIM_RST  8'h00

// timer_control fields
`define EBTP_CSEL_HI  7
`define EBTP_CSEL_LO  4
`define EBTP_OSEL_HI  3
`define EBTP_OSEL_LO  2
`define EBTP_MODE_BIT 1
`define EBTP_INV_BIT  0

// timer_divider_setup fields
`define EBTP_RES_BIT  7
`define EBTP_PRE_HI   6
`define EBTP_PRE_LO   5
`define EBTP_SCL_HI   4
`define EBTP_SCL_LO   0

// prescaler terminal counts for /1, /4, /16, /64
`define EBTP_PRE1_LAST  6'h00
`define EBTP_PRE4_LAST  6'h03
`define EBTP_PRE16_LAST 6'h0F
`define EBTP_PRE64_LAST 6'h3F

// clock source sampler lanes
`define EBTP_SRC_FAST 0
`define EBTP_SRC_XTAL 1
`define EBTP_SRC_SLOW 2
`define EBTP_SRC_CMP  3
`define EBTP_SRC_OPA  4
`define EBTP_SRC_A0   5
`define EBTP_SRC_B0   6
`define EBTP_SRC_A4   7
`define EBTP_SRC_N    8

`endif

// ===== core/ebtp_pkg.sv
package ebtp_pkg;

	typedef enum logic [3:0] {
		CS_STOP = 4'h0,
		CS_SYS  = 4'h1,
		CS_FAST = 4'h2,
		CS_XTAL = 4'h3,
		CS_SLOW = 4'h4,
		CS_CMP  = 4'h5,
		CS_OPA  = 4'h6,
		CS_A0_R = 4'h8,
		CS_A0_F = 4'h9,
		CS_B0_R = 4'hA,
		CS_B0_F = 4'hB,
		CS_A4_R = 4'hC,
		CS_A4_F = 4'hD
	} ebtp_csel_t;

	typedef enum logic {MD_PERIOD = 1'b0, MD_PWM = 1'b1} ebtp_mode_t;

	typedef enum logic [1:0] {OS_NONE = 2'h0, OS_B5 = 2'h1, OS_B6 = 2'h2, OS_B7 = 2'h3} ebtp_osel_t;

	typedef enum logic [1:0] {PS_1 = 2'h0, PS_4 = 2'h1, PS_16 = 2'h2, PS_64 = 2'h3} ebtp_pre_t;

endpackage : ebtp_pkg

// ===== core/ebtp_tick_if.sv
interface ebtp_tick_if;
	logic                src_tick;
	ebtp_pkg::ebtp_pre_t pre;
	logic [4:0]          scale;
	logic                restart;
	logic                cnt_tick;

	modport ctl (output src_tick, output pre, output scale, output restart, input cnt_tick);
	modport div (input src_tick, input pre, input scale, input restart, output cnt_tick);
endinterface : ebtp_tick_if

// ===== core/ebtp_divider.sv
`include "ebtp_regs.svh"

module ebtp_divider (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// tick path
	ebtp_tick_if.div tk
);
	import ebtp_pkg::*;

	logic [5:0] pre_q;
	logic [5:0] pre_max;
	logic [4:0] scl_q;
	logic       pre_tick;

	always_comb begin
		case (tk.pre)
			PS_1:    pre_max = `EBTP_PRE1_LAST;
			PS_4:    pre_max = `EBTP_PRE4_LAST;
			PS_16:   pre_max = `EBTP_PRE16_LAST;
			default: pre_max = `EBTP_PRE64_LAST;
		endcase
	end

	// >= so a lowered factor mid-count cannot run away
	assign pre_tick = tk.src_tick && (pre_q >= pre_max);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 6'h00;
		end else if (tk.restart) begin
			pre_q <= 6'h00;
		end else if (tk.src_tick) begin
			pre_q <= pre_tick ? 6'h00 : pre_q + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 5'h00;
		end else if (tk.restart) begin
			scl_q <= 5'h00;
		end else if (pre_tick) begin
			scl_q <= (scl_q >= tk.scale) ? 5'h00 : scl_q + 5'h01;
		end
	end

	assign tk.cnt_tick = pre_tick && (scl_q >= tk.scale);

	default clocking dcb @(posedge pclk); endclocking
	default disable iff (!presetn);

	tick_from_src_a: assert property (tk.cnt_tick |-> tk.src_tick)
		else $error("counter tick without a source tick");
	pre_gap_a: assert property (pre_tick && tk.pre != PS_1 && !tk.restart |=> !pre_tick)
		else $error("prescaler fired twice in a row");
endmodule : ebtp_divider

// ===== verification/ebtp_load_model.sv
module ebtp_load_model (
	// clock
	input  wire logic        pclk,
	// waveform pins and their enables
	input  wire logic [2:0]  pin,
	input  wire logic [2:0]  pin_oe,
	// measurement control
	input  wire logic        clr,
	// resolved net and measured runs
	output logic             level,
	output logic      [15:0] hi_len,
	output logic      [15:0] lo_len
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] run_q  = 16'h0000;
	logic        prev_q = 1'b0;

	// the load pulls the net low while no pin drives it
	assign level = |(pin & pin_oe);

	// a run is only recorded once it ends, so a stuck net leaves the lengths cleared
	always_ff @(posedge pclk) begin
		prev_q <= level;
		run_q  <= (level == prev_q) ? run_q + 16'h0001 : 16'h0001;
		if (clr) begin
			hi_len <= 16'h0000;
			lo_len <= 16'h0000;
		end else if (level != prev_q) begin
			if (prev_q)
				hi_len <= run_q;
			else
				lo_len <= run_q;
		end
	end
endmodule : ebtp_load_model

// ===== verification/eight_bit_timer_pwm_tb.sv
`include "ebtp_regs.svh"

module eight_bit_timer_pwm_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [3:0] SRC_CODES [11] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
	localparam logic [3:0] OFF_CODES [4]  = '{4'h0, 4'h7, 4'hE, 4'hF};

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic        halt    = 1'b0;
	logic        clr     = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [7:0]  src     = 8'h00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  pin;
	logic [2:0]  oe;
	logic        level;
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	int          errors  = 0;
	int          n_tests = 0;
	int          cyc     = 0;

	initial begin
		forever #12.5 pclk = ~pclk;
	end

	ebtp_timer #(.GATE_CMP(1'b1)) ebtp_timer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fast_internal_oscillator(src[0]), .crystal_oscillator(src[1]), .slow_internal_oscillator(src[2]),
		.comparator_result(src[3]), .op_amp_result(src[4]), .port_a_line_zero(src[5]),
		.port_b_line_zero(src[6]), .port_a_line_four(src[7]), .in_circuit_emulator_halt(halt),
		.port_b_line_five(pin[0]), .port_b_line_five_oe(oe[0]), .port_b_line_six(pin[1]),
		.port_b_line_six_oe(oe[1]), .port_b_line_seven(pin[2]), .port_b_line_seven_oe(oe[2]));

	ebtp_load_model ebtp_load_model_i (.pclk(pclk), .pin(pin), .pin_oe(oe), .clr(clr), .level(level),
		.hi_len(hi_len), .lo_len(lo_len));

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk(n, 32'h1, "bus answer"); // zero wait states
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask : wr

	task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 8'h00, r, e);
		chk(r, exp, what);
	endtask : rdc

	task automatic pulse(input logic [7:0] m, input int n);
		repeat (n) begin
			@(posedge pclk);
			src <= m;
			repeat (4) @(posedge pclk);
			src <= 8'h00;
			repeat (4) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask : pulse

	task automatic measure(input int n);
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask : measure

	task automatic wave(input logic [7:0] ctl, input logic [7:0] div, input logic [7:0] lim,
		input logic [15:0] hi, input logic [15:0] lo, input logic [2:0] oe_exp);
		wr(`EBTP_IDX_DIV, div);
		wr(`EBTP_IDX_LIM, lim);
		wr(`EBTP_IDX_CNT, 8'h00);
		wr(`EBTP_IDX_CTRL, ctl);
		measure(700);
		chk({16'h0, hi_len}, {16'h0, hi}, "high run"); // high time
		chk({16'h0, lo_len}, {16'h0, lo}, "low run"); // low time
		chk({29'h0, oe}, {29'h0, oe_exp}, "pin enables"); // output pin
	endtask : wave

	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rdc(`EBTP_IDX_CTRL, 32'h0, "control reset"); // stopped at reset
		rdc(`EBTP_IDX_CNT, 32'h0, "counter reset"); // counter reset
		wr(`EBTP_IDX_LIM, 8'hFF);
		rdc(`EBTP_IDX_LIM, 32'h0, "limit reads zero"); // bound write only
		wr(`EBTP_IDX_CNT, 8'hA5);
		rdc(`EBTP_IDX_CNT, 32'hA5, "counter preload"); // preload
		apb(1'b0, 6'h35, 8'h00, r, e);
		chk({31'h0, e}, 32'h1, "unmapped error"); // unmapped word
		$display("test regs done");
	endtask : t_regs

	task automatic t_hold();
		wr(`EBTP_IDX_CNT, 8'h5A);
		foreach (OFF_CODES[i]) begin
			wr(`EBTP_IDX_CTRL, {OFF_CODES[i], 4'hA});
			pulse(8'hFF, 2);
			rdc(`EBTP_IDX_CNT, 32'h5A, "counter holds"); // no ticks
		end
		$display("test hold done");
	endtask : t_hold

	task automatic t_sources();
		int k;
		wr(`EBTP_IDX_DIV, 8'h00);
		wr(`EBTP_IDX_LIM, 8'hFF);
		foreach (SRC_CODES[i]) begin
			k = (SRC_CODES[i] < 4'h8) ? int'(SRC_CODES[i]) - 2 : 5 + (int'(SRC_CODES[i]) - 8) / 2;
			wr(`EBTP_IDX_CTRL, {SRC_CODES[i], 4'h0});
			wr(`EBTP_IDX_CNT, 8'h00);
			pulse(8'h01 << k, 3);
			rdc(`EBTP_IDX_CNT, 32'h3, "edges counted"); // source codes
		end
		$display("test sources done");
	endtask : t_sources

	task automatic t_halt();
		halt <= 1'b1;
		wr(`EBTP_IDX_CTRL, 8'h10);
		wr(`EBTP_IDX_CNT, 8'h00);
		repeat (20) @(posedge pclk);
		rdc(`EBTP_IDX_CNT, 32'h0, "halt stops system clock"); // halted
		wr(`EBTP_IDX_CTRL, 8'h20);
		pulse(8'h01, 4);
		rdc(`EBTP_IDX_CNT, 32'h4, "fast clock runs in halt"); // fast source
		halt <= 1'b0;
		$display("test halt done");
	endtask : t_halt

	task automatic t_pwm();
		wave(8'h1A, 8'h00, 8'h7F, 16'd128, 16'd128, 3'b010); // half duty
		wave(8'h1A, 8'h00, 8'h09, 16'd10, 16'd246, 3'b010); // duty compare
		wave(8'h1B, 8'h00, 8'h09, 16'd246, 16'd10, 3'b010); // inverted
		wave(8'h1E, 8'h00, 8'hFE, 16'd255, 16'd1, 3'b100); // top boundary
		wave(8'h16, 8'h80, 8'h00, 16'd1, 16'd63, 3'b001); // reduced width
		wave(8'h16, 8'hA0, 8'h1F, 16'd128, 16'd128, 3'b001); // prescale four
		$display("test pwm done");
	endtask : t_pwm

	task automatic t_period();
		wave(8'h14, 8'h00, 8'h03, 16'd4, 16'd4, 3'b001); // square wave
		wave(8'h18, 8'h41, 8'h01, 16'd64, 16'd64, 3'b010); // scaler plus one
		$display("test period done");
	endtask : t_period

	task automatic t_gate();
		src <= 8'h08;
		wave(8'h1A, 8'h00, 8'h7F, 16'd0, 16'd0, 3'b010); // suppressed
		src <= 8'h00;
		wave(8'h1A, 8'h00, 8'h7F, 16'd128, 16'd128, 3'b010); // resumed
		$display("test gate done");
	endtask : t_gate

	// cuts a hang short well beyond the longest expected run
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			end_of_test();
		end
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_hold();
		t_sources();
		t_halt();
		t_pwm();
		t_period();
		t_gate();
		end_of_test();
	end
endmodule : eight_bit_timer_pwm_tb
